// *** core/cmd_unit.v ***
// Coprocessor multiply/divide unit: sixteen byte registers, operation
// sequencing and result write-back.
// Assumes the CPU transfer port is synchronous to clk and accesses are aligned.
//
// How it works
// - Multiply 16x16, product ready four cycles after start.
// - Divide 32 by 16, quotient and remainder ready after eight cycles.
// - Divide 32 by 32, quotient and remainder ready after sixteen cycles.
// - Multiply-accumulate without saturation, finished within four cycles.
// - Saturating multiply-accumulate, also finished within four cycles.
// - Saturation clamps to largest positive or most negative value.
// - Signed mode treats operand and result top bits as sign.
// - Writing the top operand byte starts the operation; CPU writes it last.
// - The five unused bytes read zero and ignore writes.
// - Top register is a read-only fixed identity byte.
// - Byte registers also reachable as aligned 16, 32, 64-bit groups.
// - Operand bytes hold inputs, then receive results in place.
// - Multiplicand bytes 6-7, multiplier 4-5, addend and result 0-3.
// - Division dividend/quotient 0-3; divisor and remainder per width.
// - Operand bytes without a result keep their contents.
// - Mode register selects operation, signedness and enable.
// - Status flags are captured when each operation completes.
// - Select codes 0,1,2,3,5 operate; 4,6,7 do nothing.
// - Mode bit 4 signed, bit 7 enable; clearing blocks next start only.
// - Carry, zero, negative, overflow per operation; sticky saturation; all writable.
// - Busy bit at word bit 8 reads one while operating.
`timescale 1ns/10ps
`include "cmd_defs.vh"

module cmd_unit
(
   // Clock and reset
   input  wire        clk,
   input  wire        srst,
   // Coprocessor transfer port
   input  wire [3:0]  copAddr,
   input  wire [1:0]  copSize,
   input  wire        copWrite,
   input  wire        copRead,
   input  wire [63:0] copWrData,
   output wire [63:0] copRdData,
   // Status
   output wire        opBusy
);

   // Number of bytes in one access
   function [4:0] sizeLen;
      input [1:0] size;
      begin
         case (size)
            `CMD_SIZE_BYTE:  sizeLen = 5'h01;
            `CMD_SIZE_WORD:  sizeLen = 5'h02;
            `CMD_SIZE_DWORD: sizeLen = 5'h04;
            default:         sizeLen = 5'h08;
         endcase
      end
   endfunction

   // Aligned base of an access
   function [3:0] alignBase;
      input [3:0] addr;
      input [1:0] size;
      begin
         case (size)
            `CMD_SIZE_BYTE:  alignBase = addr;
            `CMD_SIZE_WORD:  alignBase = {addr[3:1], 1'b0};
            `CMD_SIZE_DWORD: alignBase = {addr[3:2], 2'h0};
            default:         alignBase = {addr[3], 3'h0};
         endcase
      end
   endfunction

   // Operation time of a select code; zero means no operation
   function [4:0] opCycles;
      input [2:0] sel;
      begin
         case (sel)
            `CMD_OP_MUL:    opCycles = `CMD_CYC_MUL;
            `CMD_OP_MAC:    opCycles = `CMD_CYC_MUL;
            `CMD_OP_MACSAT: opCycles = `CMD_CYC_MUL;
            `CMD_OP_DIV16:  opCycles = `CMD_CYC_DIV16;
            `CMD_OP_DIV32:  opCycles = `CMD_CYC_DIV32;
            default:        opCycles = 5'h00;
         endcase
      end
   endfunction

   // Sequencer states
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;

   reg  [63:0]  opnd_q;
   reg  [7:0]   mode_q;
   reg  [7:0]   stat_q;
   reg  [1:0]   state_q;
   reg  [4:0]   cnt_q;
   reg  [2:0]   op_q;
   reg          sign_q;
   reg  [63:0]  snap_q;
   reg  [63:0]  rdData_q;
   reg  [1:0]   state_d;
   reg  [4:0]   cnt_d;
   reg  [7:0]   stat_d;
   reg  [31:0]  resLo;
   reg  [31:0]  resHi;
   reg  [7:0]   resMask;
   reg  [3:0]   resFlags;
   reg  [3:0]   resUpd;
   reg          resSat;
   reg  [63:0]  opnd_d;
   integer      k;
   integer      j;

   wire [3:0]   base = alignBase(copAddr, copSize);
   wire [4:0]   len  = sizeLen(copSize);
   wire [15:0]  wrHit;
   wire [127:0] wrLane;
   wire [63:0]  opndWr;
   wire [63:0]  rdLanes;
   wire         busy     = state_q[1];
   wire         doneFire = busy && (cnt_q == 5'h00);
   wire [4:0]   selCyc   = opCycles(mode_q[`CMD_MODE_SEL]);
   // Enable is sampled at the start only, so clearing it never cuts a run short
   wire         startReq = copWrite && wrHit[`CMD_IDX_OPND_TOP] && !busy &&
                           mode_q[`CMD_MODE_EN] && (selCyc != 5'h00);
   wire [7:0]   statRead = {stat_q[7:1], busy};
   // Unused bytes 10 to 14 are constant zero and have no storage
   wire [127:0] space    = {`CMD_ID_VALUE, 40'h0000000000, statRead, mode_q, opnd_q};

   // Byte decode of one aligned access over the sixteen-byte space
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1)
      begin : gByte
         // Genvars are copied into sized wires so no index is cut silently
         wire [31:0] gIdx = g;
         wire [3:0]  idx  = gIdx[3:0];
         wire [3:0] off = idx - base;
         assign wrHit[g] = copWrite && (idx >= base) && ({1'b0, off} < len);
         assign wrLane[g*8 +: 8] = copWrData[off[2:0]*8 +: 8];
      end
      for (g = 0; g < 8; g = g + 1)
      begin : gLane
         wire [31:0] gOff = g;
         wire [3:0]  ridx = base + gOff[3:0];
         assign rdLanes[g*8 +: 8] = (g < len) ? space[ridx*8 +: 8] : 8'h00;
         assign opndWr[g*8 +: 8]  = wrHit[g] ? wrLane[g*8 +: 8] : opnd_q[g*8 +: 8];
      end
   endgenerate

   // Datapaths read the operand snapshot taken at the start
   wire [31:0] macRes;
   wire [3:0]  macFlags;
   wire [3:0]  macUpd;
   wire        macSat;
   wire [31:0] divQuot;
   wire [31:0] divRem;
   wire [3:0]  divFlags;
   wire [3:0]  divUpd;

   cmd_mac uMac
   (
      .signedOp   (sign_q),
      .accumulate (op_q != `CMD_OP_MUL),
      .saturate   (op_q == `CMD_OP_MACSAT),
      .mcand      (snap_q[63:48]),
      .mplier     (snap_q[47:32]),
      .addend     (snap_q[31:0]),
      .result     (macRes),
      .flags      (macFlags),
      .updMask    (macUpd),
      .satHit     (macSat)
   );

   cmd_div uDiv
   (
      .signedOp   (sign_q),
      .wide       (op_q == `CMD_OP_DIV32),
      .dividend   (snap_q[31:0]),
      .divisorRaw (snap_q[63:32]),
      .quot       (divQuot),
      .rem        (divRem),
      .flags      (divFlags),
      .updMask    (divUpd)
   );

   // Result routing per operation
   always @*
   begin
      resLo    = macRes;
      resHi    = 32'h00000000;
      resMask  = `CMD_RES_LOW;
      resFlags = macFlags;
      resUpd   = macUpd;
      resSat   = macSat;
      case (op_q)
         `CMD_OP_DIV16:
         begin
            resLo    = divQuot;
            resHi    = {16'h0000, divRem[15:0]};
            resMask  = `CMD_RES_DIV16;
            resFlags = divFlags;
            resUpd   = divUpd;
            resSat   = 1'b0;
         end
         `CMD_OP_DIV32:
         begin
            resLo    = divQuot;
            resHi    = divRem;
            resMask  = `CMD_RES_DIV32;
            resFlags = divFlags;
            resUpd   = divUpd;
            resSat   = 1'b0;
         end
         default:
         begin
            resLo    = macRes;
         end
      endcase
   end

   // Result bytes, lowest operand index first
   wire [63:0] resAll = {resHi, resLo};

   // Operand next value: a finishing result wins over a software write on
   // the same byte, and bytes outside the result mask keep their contents
   always @*
   begin
      opnd_d = opndWr;
      for (j = 0; j < 8; j = j + 1)
      begin
         if (doneFire && resMask[j])
            opnd_d[j*8 +: 8] = resAll[j*8 +: 8];
      end
   end

   // Sequencer next state
   always @*
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         ST_IDLE:
         begin
            if (startReq)
            begin
               state_d = ST_RUN;
               cnt_d   = selCyc - 5'h01;
            end
         end
         ST_RUN:
         begin
            if (cnt_q == 5'h00)
               state_d = ST_IDLE;
            else
               cnt_d = cnt_q - 5'h01;
         end
         default:
         begin
            state_d = ST_IDLE;
            cnt_d   = 5'h00;
         end
      endcase
   end

   // Status next value: completion flags win over a software write
   always @*
   begin
      stat_d = stat_q;
      if (wrHit[`CMD_IDX_STATUS])
         stat_d = wrLane[`CMD_IDX_STATUS*8 +: 8] & `CMD_ST_WMASK;
      if (doneFire)
      begin
         for (k = 0; k < 4; k = k + 1)
         begin
            if (resUpd[k])
               stat_d[`CMD_ST_OV + k] = resFlags[k];
         end
         if (resSat)
            stat_d[`CMD_ST_Q] = 1'b1;
      end
      stat_d[`CMD_ST_BUSY] = 1'b0;
   end

   // Sequencer and operation snapshot
   always @(posedge clk)
   begin
      if (srst)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 5'h00;
         op_q    <= `CMD_OP_MUL;
         sign_q  <= 1'b0;
         snap_q  <= 64'h0000000000000000;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         if (startReq)
         begin
            op_q   <= mode_q[`CMD_MODE_SEL];
            sign_q <= mode_q[`CMD_MODE_SIGN];
            snap_q <= opndWr;
         end
      end
   end

   // Operand, mode and status registers
   always @(posedge clk)
   begin
      if (srst)
      begin
         opnd_q <= 64'h0000000000000000;
         mode_q <= 8'h00;
         stat_q <= 8'h00;
      end
      else
      begin
         opnd_q <= opnd_d;
         if (wrHit[`CMD_IDX_MODE])
            mode_q <= wrLane[`CMD_IDX_MODE*8 +: 8] & `CMD_MODE_WMASK;
         stat_q <= stat_d;
      end
   end

   // Registered read port; results land on the last busy edge, so the CPU
   // reads one edge later, after the full operation time
   always @(posedge clk)
   begin
      if (srst)
         rdData_q <= 64'h0000000000000000;
      else if (copRead)
         rdData_q <= rdLanes;
   end

   assign copRdData = rdData_q;
   assign opBusy    = state_q[1];

endmodule // cmd_unit

// *** core/cmd_defs.vh ***
// Constants shared by the coprocessor multiply/divide unit files.
// Assumes inclusion by bare name; holds definitions only.
`ifndef CMD_DEFS_VH
`define CMD_DEFS_VH

// Register indices in the sixteen-byte space
`define CMD_IDX_OPND_TOP 4'h7
`define CMD_IDX_MODE     4'h8
`define CMD_IDX_STATUS   4'h9

// Access sizes of the transfer port
`define CMD_SIZE_BYTE  2'h0
`define CMD_SIZE_WORD  2'h1
`define CMD_SIZE_DWORD 2'h2
`define CMD_SIZE_QWORD 2'h3

// Mode register fields
`define CMD_MODE_EN     7
`define CMD_MODE_SIGN   4
`define CMD_MODE_SEL    2:0
`define CMD_MODE_WMASK  8'h97

// Status register fields; busy is bit 8 of the mode/status word
`define CMD_ST_C        7
`define CMD_ST_Z        6
`define CMD_ST_S        5
`define CMD_ST_OV       4
`define CMD_ST_Q        3
`define CMD_ST_BUSY     0
`define CMD_ST_FLAGS    7:4
`define CMD_ST_WMASK    8'hF8

// Operation select codes
`define CMD_OP_MUL    3'h0
`define CMD_OP_DIV16  3'h1
`define CMD_OP_MAC    3'h2
`define CMD_OP_MACSAT 3'h3
`define CMD_OP_DIV32  3'h5

// Operation times in clock cycles
`define CMD_CYC_MUL   5'h04
`define CMD_CYC_DIV16 5'h08
`define CMD_CYC_DIV32 5'h10

// Operand bytes that receive a result
`define CMD_RES_LOW   8'h0F
`define CMD_RES_DIV16 8'h3F
`define CMD_RES_DIV32 8'hFF

// Fixed values
`define CMD_SAT_POS   32'h7FFFFFFF
`define CMD_SAT_NEG   32'h80000000
`define CMD_ALL_ONES  32'hFFFFFFFF
`define CMD_ID_VALUE  8'h5A

`endif

// *** core/cmd_mac.v ***
// Multiply and multiply-accumulate datapath, purely combinational.
// Assumes the caller holds operands stable for the whole operation time.
`timescale 1ns/10ps
`include "cmd_defs.vh"

module cmd_mac
(
   // Control
   input  wire        signedOp,
   input  wire        accumulate,
   input  wire        saturate,
   // Operands
   input  wire [15:0] mcand,
   input  wire [15:0] mplier,
   input  wire [31:0] addend,
   // Result and flags {c, z, s, ov}
   output wire [31:0] result,
   output wire [3:0]  flags,
   output wire [3:0]  updMask,
   output wire        satHit
);

   wire signed [31:0] prodS = $signed(mcand) * $signed(mplier);
   wire        [31:0] prodU = mcand * mplier;
   wire        [31:0] prod  = signedOp ? prodS : prodU;
   wire        [31:0] addv  = accumulate ? addend : 32'h00000000;
   wire        [32:0] sumU  = {1'b0, prod} + {1'b0, addv};
   wire        [31:0] sum32 = sumU[31:0];
   wire               ovS   = (prod[31] == addv[31]) && (sum32[31] != prod[31]);
   wire               ov    = signedOp ? ovS : sumU[32];
   // Unsigned overflow clamps to all ones, the top of the unsigned range
   wire        [31:0] satv  = !signedOp ? `CMD_ALL_ONES :
                              (prod[31] ? `CMD_SAT_NEG : `CMD_SAT_POS);

   assign satHit  = saturate && ov;
   assign result  = satHit ? satv : sum32;
   assign flags   = {sumU[32], result == 32'h00000000, result[31], ov};
   // Plain multiply only reports zero, and sign when signed
   assign updMask = accumulate ? 4'hF : {1'b0, 1'b1, signedOp, 1'b0};

endmodule // cmd_mac

// *** core/cmd_div.v ***
// Division datapath for 32/16 and 32/32, purely combinational.
// Assumes the caller holds operands stable for the whole operation time.
`timescale 1ns/10ps
`include "cmd_defs.vh"

module cmd_div
(
   // Control
   input  wire        signedOp,
   input  wire        wide,
   // Operands
   input  wire [31:0] dividend,
   input  wire [31:0] divisorRaw,
   // Results and flags {c, z, s, ov}
   output wire [31:0] quot,
   output wire [31:0] rem,
   output wire [3:0]  flags,
   output wire [3:0]  updMask
);

   // Narrow divisor sits in the upper half of the raw word
   wire [31:0] divisor = wide ? divisorRaw :
                         {{16{signedOp & divisorRaw[31]}}, divisorRaw[31:16]};
   wire        negA    = signedOp && dividend[31];
   wire        negB    = signedOp && divisor[31];
   wire [31:0] magA    = negA ? (32'h00000000 - dividend) : dividend;
   wire [31:0] magB    = negB ? (32'h00000000 - divisor) : divisor;
   wire        byZero  = (divisor == 32'h00000000);
   // Guard keeps the divide operator away from a zero divisor
   wire [31:0] safeB   = byZero ? 32'h00000001 : magB;
   wire [31:0] qMag    = magA / safeB;
   wire [31:0] rMag    = magA % safeB;
   wire        ov      = signedOp && (dividend == `CMD_SAT_NEG) && (divisor == `CMD_ALL_ONES);

   assign quot    = byZero ? `CMD_ALL_ONES :
                    ((negA ^ negB) ? (32'h00000000 - qMag) : qMag);
   assign rem     = byZero ? dividend : (negA ? (32'h00000000 - rMag) : rMag);
   assign flags   = {byZero, quot == 32'h00000000, quot[31], ov};
   assign updMask = signedOp ? 4'hF : 4'hC;

endmodule // cmd_div

// *** dv/cmd_unit_chk.sv ***
// Checker for the multiply/divide unit, watching only its transfer port and its busy output.
// Assumes the mode byte changes only through writes seen on that port.
`timescale 1ns/10ps
`include "cmd_defs.vh"

module cmd_unit_chk
(
   // Clock and reset
   input wire        clk,
   input wire        srst,
   // Transfer port and busy status
   input wire [3:0]  copAddr,
   input wire [1:0]  copSize,
   input wire        copWrite,
   input wire        copRead,
   input wire [63:0] copWrData,
   input wire [63:0] copRdData,
   input wire        opBusy
);
   logic [7:0] modeQ;
   logic [4:0] cntQ;
   logic [4:0] lenQ;
   wire  [2:0] sel = modeQ[2:0];
   wire        hitMode;
   wire        hitTop;
   wire        start;
   wire        noStart;
   wire        wordMode = copRead && copSize == 2'h1 && copAddr[3:1] == 3'h4;

   // Aligned access covers index i when the address matches above the size bits
   function automatic logic covers(input [3:0] a, input [1:0] s, input [3:0] i);
      covers = ((a ^ i) >> s) == 4'h0;
   endfunction

   assign hitMode = copWrite && covers(copAddr, copSize, 4'h8);
   assign hitTop  = copWrite && covers(copAddr, copSize, 4'h7);
   assign start   = hitTop && !opBusy && modeQ[7] && sel != 3'h4 && sel < 3'h6;
   assign noStart = hitTop && !opBusy && !start;

   always @(posedge clk)
   begin
      if (srst)
      begin
         modeQ <= 8'h00;
         cntQ  <= 5'h00;
         lenQ  <= 5'h00;
      end
      else
      begin
         if (hitMode)
            modeQ <= copWrData[7:0];
         if (start)
            lenQ <= (sel == 3'h1) ? 5'h08 : (sel == 3'h5) ? 5'h10 : 5'h04;
         cntQ <= opBusy ? cntQ + 5'h01 : 5'h00;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_mul_time: assert property (start && (sel == 3'h0 || sel[2:1] == 2'h1) |=>
      opBusy [*4] ##1 !opBusy) else $error("multiply busy span wrong");
   a_div16_time: assert property (start && sel == 3'h1 |=> opBusy [*8] ##1 !opBusy)
      else $error("32/16 divide busy span wrong");
   a_op_length: assert property ($fell(opBusy) |-> cntQ == lenQ)
      else $error("operation length differs from its mode");
   a_no_start: assert property (noStart |=> !opBusy)
      else $error("disabled or void mode started an operation");
   a_start_only: assert property ($rose(opBusy) |-> $past(start))
      else $error("busy rose without a top byte write");
   a_busy_word: assert property (wordMode ##1 opBusy == $past(opBusy) |->
      copRdData[8] == opBusy) else $error("busy bit differs from busy port");
   a_top_group: assert property (copRead && copSize == 2'h3 && copAddr[3] |=>
      copRdData[63:16] == {`CMD_ID_VALUE, 40'h0}) else $error("upper bank read wrong");
   a_byte_lanes: assert property (copRead && copSize == 2'h0 |=> copRdData[63:8] == 56'h0)
      else $error("byte read drives upper lanes");

   c_div32: cover property (start && sel == 3'h5);
   c_void: cover property (noStart);
   c_div16_done: cover property ($fell(opBusy) && lenQ == 5'h08);
endmodule // cmd_unit_chk

bind cmd_unit cmd_unit_chk cmd_unit_chk_i (.clk(clk), .srst(srst), .copAddr(copAddr),
   .copSize(copSize), .copWrite(copWrite), .copRead(copRead), .copWrData(copWrData),
   .copRdData(copRdData), .opBusy(opBusy));

// *** dv/cmd_cpu_model.sv ***
// CPU side model issuing coprocessor transfers to the unit.
// Assumes the caller waits for each task to return before the next.
`timescale 1ns/10ps

module cmd_cpu_model
(
   // Clock
   input wire         clk,
   // Transfer port
   output logic [3:0]  copAddr,
   output logic [1:0]  copSize,
   output logic        copWrite,
   output logic        copRead,
   output logic [63:0] copWrData,
   input wire  [63:0]  copRdData
);
   initial
   begin
      copAddr = 4'h0;
      copSize = 2'h0;
      copWrite = 1'b0;
      copRead = 1'b0;
      copWrData = 64'h0;
   end

   task automatic wr(input [3:0] a, input [1:0] s, input [63:0] d);
      @(posedge clk);
      copAddr <= a;
      copSize <= s;
      copWrData <= d;
      copWrite <= 1'b1;
      @(posedge clk);
      copWrite <= 1'b0;
      // Released data lines show garbage rather than the last value
      copWrData <= ~d;
   endtask

   task automatic rd(input [3:0] a, input [1:0] s, output [63:0] d);
      @(posedge clk);
      copAddr <= a;
      copSize <= s;
      copRead <= 1'b1;
      @(posedge clk);
      copRead <= 1'b0;
      #1 d = copRdData;
   endtask

   // Mode first, then the whole operand group so the top byte lands last
   task automatic op(input [7:0] m, input [63:0] o, input [3:0] slow, output [63:0] r);
      wr(4'h8, 2'h0, {56'h0, m});
      wr(4'h0, 2'h3, o);
      repeat ((m[2:0] == 3'h1 ? 7 : m[2:0] == 3'h5 ? 15 : 3) + slow) @(posedge clk);
      rd(4'h0, 2'h3, r);
   endtask
endmodule // cmd_cpu_model

// *** dv/cmd_unit_tb.sv ***
// Self-checking bench for the multiply/divide unit.
// Assumes the checker is bound to the unit and the CPU model drives its port.
`timescale 1ns/10ps
`include "cmd_defs.vh"

module cmd_unit_tb;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   wire  [3:0]  copAddr;
   wire  [1:0]  copSize;
   wire         copWrite;
   wire         copRead;
   wire  [63:0] copWrData;
   wire  [63:0] copRdData;
   wire         opBusy;
   integer      seed = 3027;
   integer      nFail = 0;
   integer      samplesChecked = 0;
   integer      i;
   logic [7:0]  m;
   logic [63:0] o;
   logic [63:0] r;
   logic [63:0] e;
   logic [7:0]  codes [14] = '{8'h80, 8'h90, 8'h81, 8'h91, 8'h82, 8'h92, 8'h83,
                               8'h93, 8'h85, 8'h95, 8'h84, 8'h86, 8'h87, 8'h00};

   always #12.5 clk = ~clk;

   cmd_cpu_model cmd_cpu_model_i (.clk(clk), .copAddr(copAddr), .copSize(copSize),
      .copWrite(copWrite), .copRead(copRead), .copWrData(copWrData), .copRdData(copRdData));
   cmd_unit cmd_unit_i (.clk(clk), .srst(srst), .copAddr(copAddr), .copSize(copSize),
      .copWrite(copWrite), .copRead(copRead), .copWrData(copWrData), .copRdData(copRdData),
      .opBusy(opBusy));

   // Operand group after one operation with mode m on operands o
   function automatic [63:0] expv(input [7:0] m, input [63:0] o);
      longint a, b, c, d, p;
      a = m[4] ? longint'($signed(o[63:48])) : longint'(o[63:48]);
      b = m[4] ? longint'($signed(o[47:32])) : longint'(o[47:32]);
      c = m[4] ? longint'($signed(o[31:0])) : longint'(o[31:0]);
      d = !m[2] ? a : m[4] ? longint'($signed(o[63:32])) : longint'(o[63:32]);
      expv = o;
      if (m[7])
         case (m[2:0])
            3'h0, 3'h2, 3'h3:
            begin
               p = a * b + (m[1] ? c : 0);
               if (m[2:0] == 3'h3 && m[4] && p > 64'sh7FFFFFFF) p = 64'sh7FFFFFFF;
               if (m[2:0] == 3'h3 && m[4] && p < -64'sh80000000) p = -64'sh80000000;
               if (m[2:0] == 3'h3 && !m[4] && p > 64'shFFFFFFFF) p = 64'shFFFFFFFF;
               expv[31:0] = p[31:0];
            end
            3'h1, 3'h5:
            begin
               p = (d == 0) ? -1 : c / d;
               expv[31:0] = p[31:0];
               p = (d == 0) ? c : c % d;
               if (m[2]) expv[63:32] = p[31:0];
               else expv[47:32] = p[15:0];
            end
            default: ;
         endcase
   endfunction

   task automatic chk(input string n, input [63:0] seen, input [63:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         nFail++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic endOfTest;
      $display("checks %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // About 200 operations of under 30 cycles each
   initial
   begin
      repeat (20000) @(posedge clk);
      nFail++;
      endOfTest;
   end

   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      cmd_cpu_model_i.rd(4'h0, 2'h3, r); chk("operands at reset", r, 64'h0);
      cmd_cpu_model_i.rd(4'h8, 2'h2, r); chk("mode status at reset", r, 64'h0);
      cmd_cpu_model_i.wr(4'h8, 2'h3, '1);
      cmd_cpu_model_i.rd(4'h8, 2'h3, r); chk("upper bank", r, {`CMD_ID_VALUE, 40'h0, 16'hF897});
      cmd_cpu_model_i.rd(4'hE, 2'h1, r); chk("identity word", r, {`CMD_ID_VALUE, 8'h0});
      // Piecewise loads: the lone top byte write must start the product
      cmd_cpu_model_i.wr(4'h8, 2'h0, 64'h80);
      cmd_cpu_model_i.wr(4'h4, 2'h1, 64'h5);
      cmd_cpu_model_i.wr(4'h6, 2'h0, 64'h7);
      cmd_cpu_model_i.wr(4'h7, 2'h0, 64'h0);
      repeat (4) @(posedge clk);
      cmd_cpu_model_i.rd(4'h0, 2'h2, r); chk("byte started product", r, 64'h23);
      cmd_cpu_model_i.rd(4'h6, 2'h1, r); chk("kept multiplicand", r, 64'h7);
      // Busy bit during a long divide
      o = {32'h0000_0007, 32'h0001_0000};
      cmd_cpu_model_i.wr(4'h8, 2'h0, 64'h85);
      cmd_cpu_model_i.wr(4'h0, 2'h3, o);
      cmd_cpu_model_i.rd(4'h8, 2'h1, r); chk("busy bit", r[8], 64'h1);
      repeat (13) @(posedge clk);
      cmd_cpu_model_i.rd(4'h0, 2'h3, r); chk("32/32 divide", r, expv(8'h85, o));
      // Enable dropped mid-run: this run finishes, the next start is blocked
      o = 64'h0000_1234_DEAD_BEEF;
      cmd_cpu_model_i.wr(4'h8, 2'h0, 64'h81);
      cmd_cpu_model_i.wr(4'h0, 2'h3, o);
      cmd_cpu_model_i.wr(4'h8, 2'h0, 64'h01);
      repeat (6) @(posedge clk);
      e = expv(8'h81, o);
      cmd_cpu_model_i.rd(4'h0, 2'h3, r); chk("divide by zero", r, e);
      cmd_cpu_model_i.rd(4'h9, 2'h0, r); chk("carry on zero divisor", r[7], 64'h1);
      cmd_cpu_model_i.wr(4'h7, 2'h0, 64'hAB);
      cmd_cpu_model_i.rd(4'h0, 2'h3, r); chk("blocked start", r, {8'hAB, e[55:0]});
      // Saturation both ways and the sticky flag
      cmd_cpu_model_i.wr(4'h9, 2'h0, 64'h0);
      o = 64'h7FFF_7FFF_7FFF_FFFF;
      cmd_cpu_model_i.op(8'h93, o, 4'h0, r); chk("clamp high", r, {o[63:32], 32'h7FFFFFFF});
      cmd_cpu_model_i.rd(4'h9, 2'h0, r); chk("clamp high flags", r, 64'h18);
      o = 64'h8000_7FFF_8000_0000;
      cmd_cpu_model_i.op(8'h93, o, 4'h1, r); chk("clamp low", r, {o[63:32], 32'h80000000});
      cmd_cpu_model_i.rd(4'h9, 2'h0, r); chk("clamp low flags", r, 64'hB8);
      cmd_cpu_model_i.op(8'h90, 64'h0003_0002_0000_0000, 4'h0, r);
      cmd_cpu_model_i.rd(4'h9, 2'h0, r); chk("sticky saturation", r[3], 64'h1);
      cmd_cpu_model_i.wr(4'h9, 2'h0, 64'h0);
      cmd_cpu_model_i.rd(4'h9, 2'h0, r); chk("saturation cleared", r[3], 64'h0);
      // Every code at least once, then random modes with some zero divisors
      for (i = 0; i < 214; i++)
      begin
         m = (i < 14) ? codes[i] : (8'($random(seed)) & 8'h97) | 8'h80;
         o = {$random(seed), $random(seed)};
         if (($random(seed) & 7) == 0) o[63:48] = 16'h0;
         cmd_cpu_model_i.op(m, o, 4'($random(seed) & 3), r);
         chk("operation result", r, expv(m, o));
      end
      endOfTest;
   end
endmodule // cmd_unit_tb
